// >>> hdl/cbs_system_config_regs.sv
// Purpose: Legacy index base and upper system control bits of a two-socket card bridge
// Assumes: One configuration request per cycle; all inputs synchronous to clock
// Notes:   Lower system control half is supplied by a neighbouring block
//          Reserved pins are only ever driven low
//          Channel four holds back card DMA requests
//
// How it works
// R1: Base decodes index port, base+1 data port
// R2: Base word aligned; bit 0 reads one
// R3: One base copy shared by both functions
// R4: Software writes global bits via function 0
// R5: Step field rotates serial interrupt slots
// R6: Tie merges second interrupt into first
// R7: Software sets terminal three first before tying
// R8: Bits 28 and 23 read zero
// R9: Clock select: external input or divided drive
// R10: Suspend needs externally supplied switch clock
// R11: Route selects IRQ2 or status-change interrupt
// R12: Socket event flag sets; write one clears
// R13: Enable raises interrupt on power writes
// R14: Drive reserved pins low when inserted
// R15: Protect-disable bit turns supply protection off
// R16: Reduced video floats upper card address
// R17: DMA enable forwards card requests
// R18: Channel field; four means unused
// R19: Global bits shared, socket bits per function
`timescale 1ns/1ns
module cbs_system_config_regs
	import cbs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  cbs_pkg::cbs_cfg_req_t cfg_req,
	input  wire logic [15:0] sysctl_low_rdata,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_read_valid,
	input  wire logic        io_valid,
	input  wire logic [31:0] io_addr,
	output logic             legacy_index_hit,
	output logic             legacy_data_hit,
	input  wire logic [1:0]  pci_int_request,
	output logic [3:0]       irq_slot_level,
	input  wire logic        ext_switch_clock,
	output logic             switch_clock_out,
	output logic             switch_clock_oe,
	output logic             switch_clock_level,
	input  wire logic [1:0]  socket_power_write,
	output logic [1:0]       smi_irq2_pulse,
	output logic [1:0]       csc_irq_pulse,
	input  wire logic [1:0]  cardbus_inserted,
	output logic [1:0]       reserved_pin_out,
	output logic [1:0]       reserved_pin_oe,
	output logic [1:0]       supply_protect_enable,
	output logic [1:0]       card_addr_upper_float,
	input  wire logic [1:0]  card_dma_request_line,
	output logic [1:0]       pc_dma_request,
	output logic [1:0][2:0]  pc_dma_channel
);
	import cbs_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [31:0]        base_reg;
	logic [31:0]        base_next;
	cbs_global_ctl_t    global_reg;
	cbs_global_ctl_t    global_next;
	logic [31:0]        rdata_reg;
	logic [31:0]        rdata_next;
	logic               read_valid_reg;
	logic               read_valid_next;
	logic [3:0]         slot_reg;
	logic [3:0]         slot_next;
	logic               switch_level_reg;
	logic               switch_level_next;
	logic [1:0]         rsvd_oe_reg;
	logic [1:0]         rsvd_oe_next;
	logic [1:0]         dma_req_reg;
	logic [1:0]         dma_req_next;
	logic [1:0][2:0]    dma_chan_reg;
	logic [1:0][2:0]    dma_chan_next;
	cbs_socket_ctl_t    sock_ctl [2];
	cbs_socket_ctl_t    sel_ctl;
	logic               wr_base;
	logic               wr_sys;
	logic [1:0]         sock_write_lo;
	logic [1:0]         sock_write_hi;
	logic [31:0]        base_addr;
	logic [31:0]        sys_upper;
	logic               merged_a;
	logic               merged_b;
	logic [1:0]         second_slot;
	logic               divided_clock;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration write decode
	assign wr_base = cfg_req.write && (cfg_req.offset == LEGACY_BASE_OFFSET); // [R3]
	assign wr_sys  = cfg_req.write && (cfg_req.offset == SYS_CONTROL_OFFSET);

	always_comb
	begin
		// Lane 2 holds socket fields, lane 3 the event flag
		sock_write_lo = 2'b00;
		sock_write_hi = 2'b00;
		sock_write_lo[cfg_req.func] = wr_sys & cfg_req.byte_en[2]; // [R19]
		sock_write_hi[cfg_req.func] = wr_sys & cfg_req.byte_en[3]; // [R19]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared legacy base address
	always_comb
	begin
		base_next = base_reg;
		if (wr_base)
		begin
			// Only enabled byte lanes change
			for (int lane = 0; lane < 4; lane++)
			begin
				if (cfg_req.byte_en[lane])
					base_next[lane*8 +: 8] = cfg_req.wdata[lane*8 +: 8];
			end
		end
		base_next[0] = LEGACY_BASE_RESET[0]; // [R2]
	end

	assign base_addr = {base_reg[31:1], 1'b0}; // [R2]

	// Index at base, data at base plus one
	assign legacy_index_hit = io_valid && (io_addr == base_addr);         // [R1]
	assign legacy_data_hit  = io_valid && (io_addr == (base_addr + 32'h1)); // [R1]

	////////////////////////////////////////////////////////////////////////////////
	// Global system control bits, one copy for both functions
	always_comb
	begin
		global_next = global_reg;
		if (wr_sys && cfg_req.byte_en[3]) // [R19]
		begin
			global_next.irq_slot_step             = cfg_req.wdata[STEP_MSB:STEP_LSB];
			global_next.irq_tie_enable            = cfg_req.wdata[TIE_BIT];
			global_next.power_switch_clock_select = cfg_req.wdata[CLKSEL_BIT];
			global_next.smi_route_select          = cfg_req.wdata[ROUTE_BIT];
			global_next.smi_signal_enable         = cfg_req.wdata[SMI_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Socket-dependent copies, one per function
	for (genvar s = 0; s < 2; s++)
	begin : g_socket
		cbs_socket_regs u_socket (
			.clock          (clock),
			.reset          (reset),
			.write_lo       (sock_write_lo[s]),
			.write_hi       (sock_write_hi[s]),
			.wdata          (cfg_req.wdata),
			.power_write    (socket_power_write[s]),
			.smi_enable     (global_reg.smi_signal_enable),
			.smi_route      (global_reg.smi_route_select),
			.ctl            (sock_ctl[s]),
			.smi_irq2_pulse (smi_irq2_pulse[s]),
			.csc_irq_pulse  (csc_irq_pulse[s])
		);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration read
	assign sel_ctl = sock_ctl[cfg_req.func];

	always_comb
	begin
		sys_upper = 32'h0;
		sys_upper[STEP_MSB:STEP_LSB] = global_reg.irq_slot_step;
		sys_upper[TIE_BIT]           = global_reg.irq_tie_enable;
		sys_upper[ZERO_HI_BIT]       = 1'b0; // [R8]
		sys_upper[CLKSEL_BIT]        = global_reg.power_switch_clock_select;
		sys_upper[ROUTE_BIT]         = global_reg.smi_route_select;
		sys_upper[SMI_FLAG_BIT]      = sel_ctl.smi_event_flag;
		sys_upper[SMI_EN_BIT]        = global_reg.smi_signal_enable;
		sys_upper[ZERO_LO_BIT]       = 1'b0; // [R8]
		sys_upper[RSVD_DRV_BIT]      = sel_ctl.reserved_pin_drive_low;
		sys_upper[PROT_BIT]          = sel_ctl.supply_protect_disable;
		sys_upper[ZV_BIT]            = sel_ctl.reduced_video_port;
		sys_upper[DMA_EN_BIT]        = sel_ctl.card_dma_request_enable;
		sys_upper[CHAN_MSB:CHAN_LSB] = sel_ctl.card_dma_channel;
		sys_upper[15:0]              = sysctl_low_rdata;
	end

	always_comb
	begin
		read_valid_next = cfg_req.read;
		rdata_next      = 32'h0;
		if (cfg_req.read)
		begin
			unique case (cfg_req.offset)
				LEGACY_BASE_OFFSET: rdata_next = base_reg; // [R3]
				SYS_CONTROL_OFFSET: rdata_next = sys_upper;
				// Unmapped offsets answer zero
				default:            rdata_next = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial interrupt slot steering
	always_comb
	begin
		merged_a    = pci_int_request[0] | (global_reg.irq_tie_enable & pci_int_request[1]); // [R6]
		merged_b    = pci_int_request[1] & ~global_reg.irq_tie_enable;                     // [R6]
		second_slot = global_reg.irq_slot_step + 2'h1;
		slot_next   = 4'h0;
		slot_next[global_reg.irq_slot_step] = merged_a;                  // [R5]
		slot_next[second_slot] = slot_next[second_slot] | merged_b;      // [R5]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-switch serial clock source
	// Next select value, so driven clock and enable fall together
	cbs_clock_divider u_divider (
		.clock         (clock),
		.reset         (reset),
		.enable        (global_next.power_switch_clock_select),
		.divided_clock (divided_clock)
	);

	always_comb
	begin
		if (global_reg.power_switch_clock_select) // [R9]
			switch_level_next = divided_clock;
		else
			switch_level_next = ext_switch_clock;
	end

	assign switch_clock_out = divided_clock;                        // [R9]
	assign switch_clock_oe  = global_reg.power_switch_clock_select; // [R9]

	////////////////////////////////////////////////////////////////////////////////
	// Card-side controls per socket
	always_comb
	begin
		for (int s = 0; s < 2; s++)
		begin
			rsvd_oe_next[s]  = sock_ctl[s].reserved_pin_drive_low & cardbus_inserted[s]; // [R14]
			dma_req_next[s]  = sock_ctl[s].card_dma_request_enable
				& card_dma_request_line[s]
				& (sock_ctl[s].card_dma_channel != DMA_CHANNEL_UNUSED); // [R17] [R18]
			dma_chan_next[s] = sock_ctl[s].card_dma_channel; // [R18]
		end
	end

	assign reserved_pin_out = 2'b00; // [R14]

	////////////////////////////////////////////////////////////////////////////////
	// Per-socket pin levels
	for (genvar s = 0; s < 2; s++)
	begin : g_pins
		assign supply_protect_enable[s] = ~sock_ctl[s].supply_protect_disable; // [R15]
		assign card_addr_upper_float[s] = sock_ctl[s].reduced_video_port;      // [R16]
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			base_reg                             <= LEGACY_BASE_RESET;
			global_reg.irq_slot_step             <= SYS_CONTROL_RESET[STEP_MSB:STEP_LSB];
			global_reg.irq_tie_enable            <= SYS_CONTROL_RESET[TIE_BIT];
			global_reg.power_switch_clock_select <= SYS_CONTROL_RESET[CLKSEL_BIT];
			global_reg.smi_route_select          <= SYS_CONTROL_RESET[ROUTE_BIT];
			global_reg.smi_signal_enable         <= SYS_CONTROL_RESET[SMI_EN_BIT]; // [R13]
			rdata_reg                            <= 32'h0;
			read_valid_reg                       <= 1'b0;
			slot_reg                             <= 4'h0;
			switch_level_reg                     <= 1'b0;
			rsvd_oe_reg                          <= 2'b00;
			dma_req_reg                          <= 2'b00;
			dma_chan_reg                         <= {2{DMA_CHANNEL_UNUSED}};
		end
		else
		begin
			base_reg         <= base_next;
			global_reg       <= global_next;
			rdata_reg        <= rdata_next;
			read_valid_reg   <= read_valid_next;
			slot_reg         <= slot_next;
			switch_level_reg <= switch_level_next;
			rsvd_oe_reg      <= rsvd_oe_next;
			dma_req_reg      <= dma_req_next;
			dma_chan_reg     <= dma_chan_next;
		end
	end

	assign cfg_rdata          = rdata_reg;
	assign cfg_read_valid     = read_valid_reg;
	assign irq_slot_level     = slot_reg;
	assign switch_clock_level = switch_level_reg;
	assign reserved_pin_oe    = rsvd_oe_reg;
	assign pc_dma_request     = dma_req_reg;
	assign pc_dma_channel     = dma_chan_reg;

endmodule : cbs_system_config_regs

// >>> hdl/cbs_pkg.sv
// Purpose: Shared constants and types of the card bridge system configuration registers
// Assumes: Configuration offsets are byte addresses within one function's space
// Notes:   Fields of the upper system control half only; the lower half lives elsewhere
package cbs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0]  LEGACY_BASE_OFFSET = 8'h44;
	localparam logic [7:0]  SYS_CONTROL_OFFSET = 8'h80;
	localparam logic [31:0] LEGACY_BASE_RESET  = 32'h00000001;
	localparam logic [31:0] SYS_CONTROL_RESET  = 32'h00449060;

	////////////////////////////////////////////////////////////////////////////////
	// System control field positions
	localparam int unsigned STEP_MSB     = 31;
	localparam int unsigned STEP_LSB     = 30;
	localparam int unsigned TIE_BIT      = 29;
	localparam int unsigned ZERO_HI_BIT  = 28;
	localparam int unsigned CLKSEL_BIT   = 27;
	localparam int unsigned ROUTE_BIT    = 26;
	localparam int unsigned SMI_FLAG_BIT = 25;
	localparam int unsigned SMI_EN_BIT   = 24;
	localparam int unsigned ZERO_LO_BIT  = 23;
	localparam int unsigned RSVD_DRV_BIT = 22;
	localparam int unsigned PROT_BIT     = 21;
	localparam int unsigned ZV_BIT       = 20;
	localparam int unsigned DMA_EN_BIT   = 19;
	localparam int unsigned CHAN_MSB     = 18;
	localparam int unsigned CHAN_LSB     = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Field meanings and timing
	localparam logic [2:0] DMA_CHANNEL_UNUSED     = 3'h4;
	localparam logic [3:0] SWITCH_CLK_HALF_CYCLES = 4'h4;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic        write;
		logic        read;
		logic        func;
		logic [7:0]  offset;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} cbs_cfg_req_t;

	typedef struct packed {
		logic [1:0] irq_slot_step;
		logic       irq_tie_enable;
		logic       power_switch_clock_select;
		logic       smi_route_select;
		logic       smi_signal_enable;
	} cbs_global_ctl_t;

	typedef struct packed {
		logic       smi_event_flag;
		logic       reserved_pin_drive_low;
		logic       supply_protect_disable;
		logic       reduced_video_port;
		logic       card_dma_request_enable;
		logic [2:0] card_dma_channel;
	} cbs_socket_ctl_t;

endpackage : cbs_pkg

// >>> hdl/cbs_clock_divider.sv
// Purpose: Power-switch serial clock made from the PCI clock
// Assumes: Enable is the next value of the clock select register, not its registered output
// Notes:   Output held low while disabled
`timescale 1ns/1ns
module cbs_clock_divider
	import cbs_pkg::*;
(
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic enable,
	output logic      divided_clock
);
	logic [3:0] count_reg;
	logic [3:0] count_next;
	logic       level_reg;
	logic       level_next;

	always_comb
	begin
		count_next = count_reg;
		level_next = level_reg;
		if (!enable)
		begin
			count_next = 4'h0;
			level_next = 1'b0;
		end
		else if (count_reg == SWITCH_CLK_HALF_CYCLES - 4'h1)
		begin
			count_next = 4'h0;
			level_next = ~level_reg;
		end
		else
		begin
			count_next = count_reg + 4'h1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			count_reg <= 4'h0;
			level_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			level_reg <= level_next;
		end
	end

	assign divided_clock = level_reg;

endmodule : cbs_clock_divider

// >>> hdl/cbs_socket_regs.sv
// Purpose: Socket-dependent system control bits, one copy per function
// Assumes: power_write is a one-cycle pulse per socket power write
// Notes:   Event flag set beats a same-cycle clear
`timescale 1ns/1ns
module cbs_socket_regs
	import cbs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        write_lo,
	input  wire logic        write_hi,
	input  wire logic [31:0] wdata,
	input  wire logic        power_write,
	input  wire logic        smi_enable,
	input  wire logic        smi_route,
	output cbs_socket_ctl_t  ctl,
	output logic             smi_irq2_pulse,
	output logic             csc_irq_pulse
);
	cbs_socket_ctl_t ctl_reg;
	cbs_socket_ctl_t ctl_next;
	logic            irq2_reg;
	logic            irq2_next;
	logic            csc_reg;
	logic            csc_next;
	logic            smi_event;

	always_comb
	begin
		ctl_next = ctl_reg;
		smi_event = power_write & smi_enable;
		if (write_lo)
		begin
			ctl_next.reserved_pin_drive_low  = wdata[RSVD_DRV_BIT];
			ctl_next.supply_protect_disable  = wdata[PROT_BIT];
			ctl_next.reduced_video_port      = wdata[ZV_BIT];
			ctl_next.card_dma_request_enable = wdata[DMA_EN_BIT];
			ctl_next.card_dma_channel        = wdata[CHAN_MSB:CHAN_LSB];
		end
		if (write_hi && wdata[SMI_FLAG_BIT])
			ctl_next.smi_event_flag = 1'b0; // [R12]
		if (smi_event)
			ctl_next.smi_event_flag = 1'b1; // [R12]
		irq2_next = smi_event & ~smi_route; // [R11] [R13]
		csc_next  = smi_event & smi_route;  // [R11] [R13]
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			ctl_reg.smi_event_flag          <= SYS_CONTROL_RESET[SMI_FLAG_BIT];
			ctl_reg.reserved_pin_drive_low  <= SYS_CONTROL_RESET[RSVD_DRV_BIT];
			ctl_reg.supply_protect_disable  <= SYS_CONTROL_RESET[PROT_BIT];
			ctl_reg.reduced_video_port      <= SYS_CONTROL_RESET[ZV_BIT];
			ctl_reg.card_dma_request_enable <= SYS_CONTROL_RESET[DMA_EN_BIT];
			ctl_reg.card_dma_channel        <= SYS_CONTROL_RESET[CHAN_MSB:CHAN_LSB];
			irq2_reg                        <= 1'b0;
			csc_reg                         <= 1'b0;
		end
		else
		begin
			ctl_reg  <= ctl_next;
			irq2_reg <= irq2_next;
			csc_reg  <= csc_next;
		end
	end

	assign ctl            = ctl_reg;
	assign smi_irq2_pulse = irq2_reg;
	assign csc_irq_pulse  = csc_reg;

endmodule : cbs_socket_regs

// >>> test/cbs_system_config_regs_asserts.sv
// Purpose: Port-level checks of the system configuration registers
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module below
`timescale 1ns/1ns
module cbs_regs_asserts
	import cbs_pkg::*;
(
	input  wire logic            clock,
	input  wire logic            reset,
	input  cbs_pkg::cbs_cfg_req_t cfg_req,
	input  wire logic [31:0]     cfg_rdata,
	input  wire logic            cfg_read_valid,
	input  wire logic [31:0]     io_addr,
	input  wire logic            legacy_index_hit,
	input  wire logic            legacy_data_hit,
	input  wire logic [1:0]      pci_int_request,
	input  wire logic [3:0]      irq_slot_level,
	input  wire logic            switch_clock_out,
	input  wire logic            switch_clock_oe,
	input  wire logic [1:0]      socket_power_write,
	input  wire logic [1:0]      smi_irq2_pulse,
	input  wire logic [1:0]      csc_irq_pulse,
	input  wire logic [1:0]      cardbus_inserted,
	input  wire logic [1:0]      reserved_pin_out,
	input  wire logic [1:0]      reserved_pin_oe,
	input  wire logic [1:0]      card_dma_request_line,
	input  wire logic [1:0]      pc_dma_request,
	input  wire logic [1:0][2:0] pc_dma_channel
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////////
	// Read request followed by its answer
	sequence s_read(logic [7:0] off);
		cfg_req.read && cfg_req.offset == off;
	endsequence
	sequence s_answer;
		##1 cfg_read_valid;
	endsequence

	a_base_bit_one: assert property (s_read(LEGACY_BASE_OFFSET) |-> s_answer ##0 cfg_rdata[0])
		else $error("base bit 0 not one");
	a_zero_bits: assert property (s_read(SYS_CONTROL_OFFSET) |-> s_answer ##0 !cfg_rdata[28] && !cfg_rdata[23])
		else $error("reserved control bits not zero");
	a_index_even: assert property (legacy_index_hit |-> !io_addr[0] && !legacy_data_hit)
		else $error("index hit on odd address");
	a_data_odd: assert property (legacy_data_hit |-> io_addr[0])
		else $error("data hit on even address");
	a_clock_idle: assert property (!switch_clock_oe |-> !switch_clock_out)
		else $error("switch clock driven while unselected");
	a_smi_route: assert property ((smi_irq2_pulse & csc_irq_pulse) == 2'b00)
		else $error("both interrupt routes pulsed");
	a_smi_cause: assert property (((smi_irq2_pulse | csc_irq_pulse) & ~$past(socket_power_write)) == 2'b00)
		else $error("interrupt without power write");
	a_rsvd_cause: assert property ((reserved_pin_oe & ~$past(cardbus_inserted)) == 2'b00 && reserved_pin_out == 2'b00)
		else $error("reserved pins driven without card");
	a_dma_cause: assert property ((pc_dma_request & ~$past(card_dma_request_line)) == 2'b00)
		else $error("dma request without card request");
	a_chan_unused: assert property ((pc_dma_request[0] |-> pc_dma_channel[0] != DMA_CHANNEL_UNUSED)
		and (pc_dma_request[1] |-> pc_dma_channel[1] != DMA_CHANNEL_UNUSED))
		else $error("dma request on unused channel");
	a_slot_cause: assert property (irq_slot_level != 4'h0 |-> $past(pci_int_request) != 2'b00)
		else $error("slot level without interrupt");
endmodule : cbs_regs_asserts

bind cbs_system_config_regs cbs_regs_asserts chk (.*);

// >>> test/cbs_host_model.sv
// Purpose: Host software issuing configuration cycles
// Assumes: Requests launched 1 ns after a rising edge
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ns
module cbs_host_model
	import cbs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_read_valid,
	output cbs_cfg_req_t     cfg_req
);
	import cbs_pkg::*;
	initial cfg_req = '0;

	// Global bits are written by callers through function 0 only
	task automatic cfg_write(input logic f, input logic [7:0] off, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge clock);
		#1;
		cfg_req = '{write: 1'b1, read: 1'b0, func: f, offset: off, byte_en: be, wdata: d};
		@(posedge clock);
		#1;
		cfg_req.write = 1'b0;
		cfg_req.wdata = ~d;
	endtask : cfg_write

	task automatic cfg_read(input logic f, input logic [7:0] off, output logic [31:0] d,
		output logic ok);
		@(posedge clock);
		#1;
		cfg_req = '{write: 1'b0, read: 1'b1, func: f, offset: off, byte_en: 4'hF,
			wdata: cfg_req.wdata};
		@(posedge clock);
		#1;
		cfg_req.read = 1'b0;
		repeat (3)
			if (cfg_read_valid !== 1'b1)
				@(posedge clock) #1;
		ok = (cfg_read_valid === 1'b1);
		d = cfg_rdata;
	endtask : cfg_read
endmodule : cbs_host_model

// >>> test/test_card_bridge_system_config_regs.sv
// Purpose: Self-checking bench of the system configuration registers
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Register table rows first, then hand-written cases
`timescale 1ns/1ns
module test_card_bridge_system_config_regs;
	import cbs_pkg::*;
	typedef struct packed {
		logic        wf;
		logic        rf;
		logic [7:0]  off;
		logic [3:0]  be;
		logic [31:0] wd;
		logic [31:0] exp;
	} cbs_row_t;
	logic                clock;
	logic                reset;
	cbs_cfg_req_t        cfg_req;
	logic [15:0]         sysctl_low_rdata = 16'h9060;
	logic [31:0]         cfg_rdata, io_addr, rd;
	logic                cfg_read_valid, io_valid, legacy_index_hit, legacy_data_hit, ok;
	logic                ext_switch_clock, switch_clock_out, switch_clock_oe, switch_clock_level;
	logic [3:0]          irq_slot_level, ones;
	logic [1:0]          pci_int_request, socket_power_write, smi_irq2_pulse, csc_irq_pulse;
	logic [1:0]          cardbus_inserted, reserved_pin_out, reserved_pin_oe;
	logic [1:0]          supply_protect_enable, card_addr_upper_float;
	logic [1:0]          card_dma_request_line, pc_dma_request;
	logic [1:0][2:0]     pc_dma_channel;
	int                  mismatches, cmp_count;
	cbs_row_t            rows [6];

	cbs_system_config_regs dut (.*);
	cbs_host_model host (.clock(clock), .cfg_rdata(cfg_rdata), .cfg_read_valid(cfg_read_valid),
		.cfg_req(cfg_req));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic finish_test();
		$display("Counts: %0d comparisons, %0d mismatches", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		chk_reg({28'h0, got}, {28'h0, exp});
	endtask : chk_pin

	task automatic read_chk(input logic f, input logic [7:0] off, input logic [31:0] exp);
		host.cfg_read(f, off, rd, ok);
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("Error at %0t: read timeout got %h expected %h", $time, rd, exp);
			finish_test();
		end
		else
			chk_reg(rd, exp);
	endtask : read_chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic power_pulse(input logic [1:0] s, input logic [3:0] exp);
		socket_power_write = s;
		tick(1);
		socket_power_write = 2'b00;
		chk_pin({smi_irq2_pulse, csc_irq_pulse}, exp);
	endtask : power_pulse

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		reset = 1'b1;
		io_valid = 1'b0;
		io_addr = 32'h0;
		ext_switch_clock = 1'b0;
		pci_int_request = 2'b00;
		socket_power_write = 2'b00;
		cardbus_inserted = 2'b00;
		card_dma_request_line = 2'b00;
		mismatches = 0;
		cmp_count = 0;
		rows[0] = '{1'b0, 1'b1, 8'h44, 4'hF, 32'h12345678, 32'h12345679};
		rows[1] = '{1'b1, 1'b0, 8'h44, 4'h3, 32'h0000ABCC, 32'h1234ABCD};
		rows[2] = '{1'b0, 1'b1, 8'h80, 4'h8, 32'hFFFF0000, 32'hED449060};
		rows[3] = '{1'b1, 1'b1, 8'h80, 4'h4, 32'h00BF0000, 32'hED3F9060};
		rows[4] = '{1'b0, 1'b0, 8'h80, 4'h0, 32'hFFFFFFFF, 32'hED449060};
		rows[5] = '{1'b0, 1'b0, 8'h84, 4'hF, 32'hFFFFFFFF, 32'h00000000};
		tick(10);
		reset = 1'b0;
		foreach (rows[i])
		begin
			host.cfg_write(rows[i].wf, rows[i].off, rows[i].be, rows[i].wd);
			read_chk(rows[i].rf, rows[i].off, rows[i].exp);
		end
		$display("Test register table done");
		chk_pin({2'h0, supply_protect_enable}, 4'h1);
		chk_pin({2'h0, card_addr_upper_float}, 4'h2);
		ones = 4'h0;
		repeat (8)
		begin
			tick(1);
			ones = ones + {3'h0, switch_clock_out};
		end
		chk_pin({switch_clock_oe, ones[2:0]}, 4'hC);
		// Terminal three taken as already set for the serial stream
		pci_int_request = 2'b10;
		tick(2);
		chk_pin(irq_slot_level, 4'h8);
		for (int s = 0; s < 4; s++)
		begin
			host.cfg_write(1'b0, SYS_CONTROL_OFFSET, 4'h8, {s[1:0], 6'h09, 24'h0});
			pci_int_request = 2'b11;
			tick(2);
			chk_pin(irq_slot_level, (4'h1 << s) | (4'h1 << ((s + 1) % 4)));
		end
		pci_int_request = 2'b10;
		tick(2);
		chk_pin(irq_slot_level, 4'h1);
		pci_int_request = 2'b00;
		$display("Test interrupt slots done");
		power_pulse(2'b01, 4'h4);
		read_chk(1'b0, SYS_CONTROL_OFFSET, 32'hCB449060);
		host.cfg_write(1'b0, SYS_CONTROL_OFFSET, 4'h8, 32'hCB000000);
		read_chk(1'b0, SYS_CONTROL_OFFSET, 32'hC9449060);
		host.cfg_write(1'b0, SYS_CONTROL_OFFSET, 4'h8, 32'hCD000000);
		power_pulse(2'b10, 4'h2);
		host.cfg_write(1'b0, SYS_CONTROL_OFFSET, 4'h8, 32'hC8000000);
		power_pulse(2'b11, 4'h0);
		read_chk(1'b1, SYS_CONTROL_OFFSET, 32'hCA3F9060);
		$display("Test smi done");
		card_dma_request_line = 2'b11;
		tick(2);
		chk_pin({1'b0, pc_dma_channel[1]}, 4'h7);
		chk_pin({2'h0, pc_dma_request}, 4'h2);
		host.cfg_write(1'b0, SYS_CONTROL_OFFSET, 4'h4, 32'h004C0000);
		tick(2);
		chk_pin({2'h0, pc_dma_request}, 4'h2);
		host.cfg_write(1'b0, SYS_CONTROL_OFFSET, 4'h4, 32'h004B0000);
		tick(2);
		chk_pin({pc_dma_request, 2'h0}, 4'hC);
		chk_pin({1'b0, pc_dma_channel[0]}, 4'h3);
		card_dma_request_line = 2'b00;
		tick(2);
		chk_pin({2'h0, pc_dma_request}, 4'h0);
		cardbus_inserted = 2'b11;
		tick(2);
		chk_pin({reserved_pin_oe, reserved_pin_out}, 4'h4);
		$display("Test dma and reserved pins done");
		io_valid = 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			io_addr = 32'h1234ABCC + k;
			tick(1);
			chk_pin({2'h0, legacy_index_hit, legacy_data_hit}, 4'h2 >> k);
		end
		$display("Test io decode done");
		reset = 1'b1;
		tick(2);
		reset = 1'b0;
		read_chk(1'b1, LEGACY_BASE_OFFSET, LEGACY_BASE_RESET);
		read_chk(1'b0, SYS_CONTROL_OFFSET, SYS_CONTROL_RESET);
		// External switch clock as supplied in suspend
		ext_switch_clock = 1'b1;
		tick(4);
		chk_pin({2'h0, switch_clock_oe, switch_clock_level}, 4'h1);
		ext_switch_clock = 1'b0;
		tick(4);
		chk_pin({3'h0, switch_clock_level}, 4'h0);
		$display("Test reset and switch clock done");
		finish_test();
	end
endmodule : test_card_bridge_system_config_regs
